// ===== hdl/slcr_defs.svh
`ifndef SLCR_DEFS_SVH
`define SLCR_DEFS_SVH

`define SLCR_ADDR_W          8
`define SLCR_OFS_RSVD_27     8'h27
`define SLCR_OFS_RSVD_28     8'h28
`define SLCR_OFS_RSVD_29     8'h29
`define SLCR_OFS_RSVD_2A     8'h2A
`define SLCR_OFS_RSVD_2B     8'h2B
`define SLCR_OFS_RSVD_2D     8'h2D
`define SLCR_OFS_RSVD_2E     8'h2E
`define SLCR_OFS_RSVD_30     8'h30
`define SLCR_OFS_HDR_TINIT   8'h31
`define SLCR_OFS_BCC         8'h32
`define SLCR_OFS_FWD         8'h33
`define SLCR_OFS_RSVD_34     8'h34
`define SLCR_OFS_STATUS      8'h3F

`define SLCR_RST_RSVD_27     8'h00
`define SLCR_RST_RSVD_28     8'h07
`define SLCR_RST_RSVD_29     8'h33
`define SLCR_RST_RSVD_2A     8'h01
`define SLCR_RST_HDR_TINIT   8'h20
`define SLCR_RST_BCC         8'h09
`define SLCR_RST_FWD         8'h04
`define SLCR_RST_ZERO        8'h00

`define SLCR_MASK_27         8'h07
`define SLCR_MASK_NIBBLES    8'h77

`define SLCR_STEP_US         100
`define SLCR_CLK_MHZ         250
`define SLCR_STEP_CYC        (`SLCR_STEP_US * `SLCR_CLK_MHZ)
`define SLCR_STEP_CNT_W      15
`define SLCR_CRC_COVER_BYTES 8
`define SLCR_NUM_VC          4
`define SLCR_PERR_CNT_MAX    8'h7F

`endif

// ===== hdl/slcr_pkg.sv
package slcr_pkg;
  typedef struct packed {
    logic [1:0] header_channel_pick;
    logic       header_source_select;
    logic       per_channel_header_capture;
    logic       rsvd3;
    logic [2:0] startup_ignore_interval;
  } slcr_hdr_tinit_s;

  typedef struct packed {
    logic       pass_all;
    logic       pass_matched;
    logic       auto_ack_all;
    logic       rsvd4;
    logic       parity_check_on;
    logic [2:0] rsvd;
  } slcr_bcc_s;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       control_sequence_crc_on;
    logic [1:0] forward_gpio_count;
  } slcr_fwd_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  vc;
    logic [31:0] raw_hdr;
    logic [31:0] corr_hdr;
    logic        interleaved;
  } slcr_pkt_hdr_s;

  typedef enum logic [1:0] {
    SLCR_ST_WAIT = 2'b00,
    SLCR_ST_RUN  = 2'b01
  } slcr_tinit_e;
endpackage

// ===== hdl/slcr_startup_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "slcr_defs.svh"
module slcr_startup_timer (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [2:0] interval_i,
  output logic            lp_ignore_o
);
  import slcr_pkg::*;
  localparam logic [`SLCR_STEP_CNT_W-1:0] STEP_LAST =
    `SLCR_STEP_CNT_W'(`SLCR_STEP_CYC - 1);

  slcr_tinit_e                 state_reg;
  logic [`SLCR_STEP_CNT_W-1:0] cyc_reg;
  logic [3:0]                  step_reg;
  wire                         step_tick = (cyc_reg == STEP_LAST);
  // code n holds off for n+1 steps; the code is read live so software
  // may lengthen the interval, and a shorter code written late ends the
  // wait at the next step instead of never matching
  wire                         done =
    step_tick && (step_reg >= {1'b0, interval_i});

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= SLCR_ST_WAIT;
      cyc_reg   <= '0;
      step_reg  <= 4'h0;
    end else if (state_reg == SLCR_ST_WAIT) begin
      cyc_reg <= step_tick ? '0 : cyc_reg + 1'b1;
      if (step_tick) begin
        step_reg <= step_reg + 4'h1;
      end
      if (done) begin
        state_reg <= SLCR_ST_RUN;
      end
    end
  end

  assign lp_ignore_o = (state_reg == SLCR_ST_WAIT);
endmodule
`default_nettype wire

// ===== hdl/slcr_header_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "slcr_defs.svh"
module slcr_header_monitor (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_n_i,
  input  wire slcr_pkg::slcr_pkt_hdr_s pkt_i,
  input  wire logic                   per_vc_i,
  input  wire logic [1:0]             vc_pick_i,
  input  wire logic                   corrected_i,
  output logic [31:0]                 hdr_o
);
  import slcr_pkg::*;
  logic [31:0] raw_reg  [`SLCR_NUM_VC];
  logic [31:0] corr_reg [`SLCR_NUM_VC];
  logic [31:0] last_raw_reg;
  logic [31:0] last_corr_reg;
  logic        last_inter_reg;

  genvar g;
  generate
    for (g = 0; g < `SLCR_NUM_VC; g++) begin : g_vc
      wire cap = pkt_i.valid && pkt_i.interleaved && per_vc_i &&
                 (pkt_i.vc == 2'(g));
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          raw_reg[g]  <= 32'h0;
          corr_reg[g] <= 32'h0;
        end else if (cap) begin
          raw_reg[g]  <= pkt_i.raw_hdr;
          corr_reg[g] <= pkt_i.corr_hdr;
        end
      end
    end
  endgenerate

  // ordinary packets always land in the shared slot
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      last_raw_reg  <= 32'h0;
      last_corr_reg <= 32'h0;
      last_inter_reg <= 1'b0;
    end else if (pkt_i.valid) begin
      last_raw_reg  <= pkt_i.raw_hdr;
      last_corr_reg <= pkt_i.corr_hdr;
      last_inter_reg <= pkt_i.interleaved;
    end
  end

  // per-channel view only follows interleaved traffic, so the enable
  // leaves plain packets untouched
  wire        use_vc  = per_vc_i && last_inter_reg;
  wire [31:0] vc_raw  = raw_reg[vc_pick_i];
  wire [31:0] vc_corr = corr_reg[vc_pick_i];
  wire [31:0] sel_raw  = use_vc ? vc_raw : last_raw_reg;
  wire [31:0] sel_corr = use_vc ? vc_corr : last_corr_reg;
  assign hdr_o = corrected_i ? sel_corr : sel_raw;
endmodule
`default_nettype wire

// ===== hdl/slcr_config_regs.sv
// Contract
// - Lane low-power control is ignored after reset for (code+1)*100 us.
// - A select bit resetting to 1 picks which header view is shown.
// - With per-channel capture on, interleaved headers are kept per VC.
// - The 2-bit channel pick selects the shown VC only while capture is on and the last header was interleaved.
// - Pass-all forwards every I2C transaction over the back channel.
// - Matched pass-through forwards only address-matched transactions.
// - Auto-acknowledge acks every I2C write regardless of lock or remote ack.
// - Back-channel parity is checked while the enable bit, reset 1, is set.
// - With CRC on, a CRC of the first 8 control bytes goes out as byte 9.
// - The GPIO count code gives 0, 1, 2 or 4 forward GPIOs, reset 0.
`timescale 1ns/100ps
`default_nettype none
`include "slcr_defs.svh"
module slcr_config_regs (
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire slcr_pkg::slcr_pkt_hdr_s pkt_i,
  output logic [31:0]                  pkt_hdr_view_o,
  output logic                         lp_ctrl_ignore_o,
  input  wire logic                    i2c_txn_i,
  input  wire logic                    i2c_addr_match_i,
  input  wire logic                    i2c_is_write_i,
  input  wire logic                    remote_ack_i,
  output logic                         i2c_forward_o,
  output logic                         i2c_ack_o,
  input  wire logic                    bc_byte_valid_i,
  input  wire logic                    bc_parity_ok_i,
  output logic                         bc_parity_check_on_o,
  output logic                         bc_parity_err_o,
  input  wire logic                    cs_byte_valid_i,
  input  wire logic [3:0]              cs_byte_idx_i,
  output logic                         cs_crc_slot_o,
  output logic [3:0]                   cs_seq_len_o,
  output logic [2:0]                   fwd_gpio_num_o,
  output logic [3:0]                   fwd_gpio_en_o
);
  import slcr_pkg::*;

  slcr_hdr_tinit_s hdr_reg;
  slcr_bcc_s       bcc_reg;
  slcr_fwd_s       fwd_reg;
  logic [7:0]      r27_reg;
  logic [7:0]      r28_reg;
  logic [7:0]      r29_reg;
  logic [7:0]      r2a_reg;
  logic [7:0]      r2e_reg [3];
  logic [7:0]      r34_reg;
  logic [7:0]      rdata_reg;
  logic            perr_reg;
  logic [7:0]      perr_cnt_reg;

  wire a_27  = (reg_addr_i == `SLCR_OFS_RSVD_27);
  wire a_28  = (reg_addr_i == `SLCR_OFS_RSVD_28);
  wire a_29  = (reg_addr_i == `SLCR_OFS_RSVD_29);
  wire a_2a  = (reg_addr_i == `SLCR_OFS_RSVD_2A);
  wire a_2b  = (reg_addr_i >= `SLCR_OFS_RSVD_2B) &&
               (reg_addr_i <= `SLCR_OFS_RSVD_2D);
  wire a_2e  = (reg_addr_i >= `SLCR_OFS_RSVD_2E) &&
               (reg_addr_i <= `SLCR_OFS_RSVD_30);
  wire a_hdr = (reg_addr_i == `SLCR_OFS_HDR_TINIT);
  wire a_bcc = (reg_addr_i == `SLCR_OFS_BCC);
  wire a_fwd = (reg_addr_i == `SLCR_OFS_FWD);
  wire a_34  = (reg_addr_i == `SLCR_OFS_RSVD_34);
  wire a_st  = (reg_addr_i == `SLCR_OFS_STATUS);
  wire [1:0] idx_2e = 2'(reg_addr_i - `SLCR_OFS_RSVD_2E);

  // reserved 0x2B-0x2D have no writable storage and read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = `SLCR_RST_ZERO;
    if (a_27) begin
      rd_mux = r27_reg;
    end else if (a_28) begin
      rd_mux = r28_reg;
    end else if (a_29) begin
      rd_mux = r29_reg;
    end else if (a_2a) begin
      rd_mux = r2a_reg;
    end else if (a_2b) begin
      rd_mux = `SLCR_RST_ZERO;
    end else if (a_2e) begin
      rd_mux = r2e_reg[idx_2e];
    end else if (a_hdr) begin
      rd_mux = hdr_reg;
    end else if (a_bcc) begin
      rd_mux = bcc_reg;
    end else if (a_fwd) begin
      rd_mux = fwd_reg;
    end else if (a_34) begin
      rd_mux = r34_reg;
    end else if (a_st) begin
      rd_mux = {perr_cnt_reg[6:0], lp_ctrl_ignore_o};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      hdr_reg <= `SLCR_RST_HDR_TINIT;
      bcc_reg <= `SLCR_RST_BCC;
      fwd_reg <= `SLCR_RST_FWD;
      r27_reg <= `SLCR_RST_RSVD_27;
      r28_reg <= `SLCR_RST_RSVD_28;
      r29_reg <= `SLCR_RST_RSVD_29;
      r2a_reg <= `SLCR_RST_RSVD_2A;
      r2e_reg <= '{default: `SLCR_RST_ZERO};
      r34_reg <= `SLCR_RST_ZERO;
    end else if (reg_wr_i) begin
      if (a_27) begin
        r27_reg <= reg_wdata_i & `SLCR_MASK_27;
      end else if (a_28) begin
        r28_reg <= reg_wdata_i & `SLCR_MASK_NIBBLES;
      end else if (a_29) begin
        r29_reg <= reg_wdata_i & `SLCR_MASK_NIBBLES;
      end else if (a_2a) begin
        r2a_reg <= reg_wdata_i & `SLCR_MASK_NIBBLES;
      end else if (a_2e) begin
        r2e_reg[idx_2e] <= reg_wdata_i;
      end else if (a_hdr) begin
        hdr_reg <= reg_wdata_i;
      end else if (a_bcc) begin
        bcc_reg <= reg_wdata_i;
      end else if (a_fwd) begin
        fwd_reg <= reg_wdata_i;
      end else if (a_34) begin
        r34_reg <= reg_wdata_i;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= `SLCR_RST_ZERO;
    end else begin
      rdata_reg <= reg_rd_i ? rd_mux : `SLCR_RST_ZERO;
    end
  end
  assign reg_rdata_o = rdata_reg;

  slcr_startup_timer u_timer (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .interval_i  (hdr_reg.startup_ignore_interval),
    .lp_ignore_o (lp_ctrl_ignore_o)
  );

  slcr_header_monitor u_mon (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .pkt_i       (pkt_i),
    .per_vc_i    (hdr_reg.per_channel_header_capture),
    .vc_pick_i   (hdr_reg.header_channel_pick),
    .corrected_i (hdr_reg.header_source_select),
    .hdr_o       (pkt_hdr_view_o)
  );

  // i2c steering is a combinational decision on the live transaction
  assign i2c_forward_o = i2c_txn_i &&
    (bcc_reg.pass_all ||
     (bcc_reg.pass_matched && i2c_addr_match_i));
  assign i2c_ack_o = i2c_txn_i &&
    ((i2c_is_write_i && bcc_reg.auto_ack_all) || remote_ack_i);

  assign bc_parity_check_on_o = bcc_reg.parity_check_on;
  wire perr_now = bc_byte_valid_i && bcc_reg.parity_check_on &&
                  !bc_parity_ok_i;
  // counter saturates so a stuck link cannot wrap back to a clean count;
  // it stops at the seven bits that software can see
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      perr_reg     <= 1'b0;
      perr_cnt_reg <= `SLCR_RST_ZERO;
    end else begin
      perr_reg <= perr_now;
      if (perr_now && (perr_cnt_reg != `SLCR_PERR_CNT_MAX)) begin
        perr_cnt_reg <= perr_cnt_reg + 8'h01;
      end
    end
  end
  assign bc_parity_err_o = perr_reg;

  assign cs_seq_len_o = fwd_reg.control_sequence_crc_on ?
    4'(`SLCR_CRC_COVER_BYTES + 1) : 4'(`SLCR_CRC_COVER_BYTES);
  assign cs_crc_slot_o = cs_byte_valid_i && fwd_reg.control_sequence_crc_on &&
    (cs_byte_idx_i == 4'(`SLCR_CRC_COVER_BYTES));

  logic [2:0] gpio_num;
  always_comb begin
    case (fwd_reg.forward_gpio_count)
      2'b00: gpio_num = 3'h0;
      2'b01: gpio_num = 3'h1;
      2'b10: gpio_num = 3'h2;
      default: gpio_num = 3'h4;
    endcase
  end
  assign fwd_gpio_num_o = gpio_num;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gpio
      assign fwd_gpio_en_o[gi] = (3'(gi) < gpio_num);
    end
  endgenerate
endmodule
`default_nettype wire

// ===== testbench/slcr_imager_model.sv
`timescale 1ns/100ps
`default_nettype none
module slcr_imager_model (
  input  wire logic               core_clk_i,
  input  wire logic               send_i,
  input  wire logic [1:0]         vc_i,
  input  wire logic               inter_i,
  output slcr_pkg::slcr_pkt_hdr_s pkt_o
);
  import slcr_pkg::*;
  initial pkt_o = '0;
  // between headers the words toggle so a stale capture cannot match
  always @(posedge core_clk_i) begin
    pkt_o.valid <= send_i;
    pkt_o.vc <= send_i ? vc_i : ~pkt_o.vc;
    pkt_o.interleaved <= inter_i;
    pkt_o.raw_hdr <= send_i ? {28'h5A5A000, 2'h0, vc_i} : ~pkt_o.raw_hdr;
    pkt_o.corr_hdr <= send_i ? {28'hC0DE000, 2'h0, vc_i} : ~pkt_o.corr_hdr;
  end
endmodule
`default_nettype wire

// ===== testbench/slcr_config_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "slcr_defs.svh"
module slcr_config_regs_assertions (
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       lp_ctrl_ignore_o,
  input wire logic       i2c_txn_i,
  input wire logic       i2c_addr_match_i,
  input wire logic       i2c_is_write_i,
  input wire logic       i2c_forward_o,
  input wire logic       i2c_ack_o,
  input wire logic       bc_byte_valid_i,
  input wire logic       bc_parity_ok_i,
  input wire logic       bc_parity_err_o,
  input wire logic [3:0] cs_seq_len_o,
  input wire logic [2:0] fwd_gpio_num_o
);
  logic [7:0] bcc_reg;
  logic [7:0] fwd_reg;
  // shadow copies, both bytes are fully writable
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      bcc_reg <= `SLCR_RST_BCC;
      fwd_reg <= `SLCR_RST_FWD;
    end else if (reg_wr_i && reg_addr_i == `SLCR_OFS_BCC) begin
      bcc_reg <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `SLCR_OFS_FWD) begin
      fwd_reg <= reg_wdata_i;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence bad_byte_s;
    bc_byte_valid_i && !bc_parity_ok_i && bcc_reg[3];
  endsequence
  sequence held_s;
    lp_ctrl_ignore_o [*8];
  endsequence
  a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside its slot");
  a_start_hold: assert property ($rose(reset_n_i) |-> held_s)
    else $error("low-power ignore dropped early");
  a_pass_all: assert property (
    i2c_txn_i && bcc_reg[7] |-> i2c_forward_o)
    else $error("pass-all did not forward");
  a_no_forward: assert property (
    i2c_txn_i && !bcc_reg[7] && !(bcc_reg[6] && i2c_addr_match_i)
    |-> !i2c_forward_o) else $error("unexpected forward");
  a_auto_ack: assert property (
    i2c_txn_i && i2c_is_write_i && bcc_reg[5] |-> i2c_ack_o)
    else $error("write not acknowledged");
  a_parity_err: assert property (bad_byte_s |=> bc_parity_err_o)
    else $error("parity error not flagged");
  a_seq_len: assert property (
    cs_seq_len_o == (fwd_reg[2] ? 4'h9 : 4'h8))
    else $error("sequence length wrong");
  a_gpio_count: assert property (
    fwd_gpio_num_o == (fwd_reg[1:0] == 2'h3 ? 3'h4 : {1'b0, fwd_reg[1:0]}))
    else $error("gpio count wrong");
endmodule
bind slcr_config_regs slcr_config_regs_assertions u_chk (.core_clk_i,
  .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .lp_ctrl_ignore_o, .i2c_txn_i, .i2c_addr_match_i, .i2c_is_write_i,
  .i2c_forward_o, .i2c_ack_o, .bc_byte_valid_i, .bc_parity_ok_i,
  .bc_parity_err_o, .cs_seq_len_o, .fwd_gpio_num_o);
`default_nettype wire

// ===== testbench/slcr_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module slcr_config_regs_tb;
  import slcr_pkg::*;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic send = 1'b0, inter = 1'b0, i2c_txn_i = 1'b0, i2c_addr_match_i = 1'b0;
  logic i2c_is_write_i = 1'b0, remote_ack_i = 1'b0, bc_byte_valid_i = 1'b0;
  logic bc_parity_ok_i = 1'b0, cs_byte_valid_i = 1'b0;
  logic [1:0] vc = 2'h0;
  logic [3:0] cs_byte_idx_i = 4'h0, cs_seq_len_o, fwd_gpio_en_o;
  logic [7:0] reg_rdata_o;
  logic [31:0] pkt_hdr_view_o;
  logic lp_ctrl_ignore_o, i2c_forward_o, i2c_ack_o, bc_parity_check_on_o;
  logic bc_parity_err_o, cs_crc_slot_o;
  logic [2:0] fwd_gpio_num_o;
  slcr_pkt_hdr_s pkt;
  int error_cnt = 0, checks_done = 0, n = 0;
  logic [7:0] ra [10] = '{8'h31, 8'h32, 8'h33, 8'h27, 8'h28, 8'h29, 8'h2A,
                          8'h2C, 8'h34, 8'h50};
  logic [7:0] re [10] = '{8'h20, 8'h09, 8'h04, 8'h00, 8'h07, 8'h33, 8'h01,
                          8'h00, 8'h00, 8'h00};
  always #2 core_clk_i = ~core_clk_i;
  slcr_config_regs DUT (.core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pkt_i(pkt), .pkt_hdr_view_o,
    .lp_ctrl_ignore_o, .i2c_txn_i, .i2c_addr_match_i, .i2c_is_write_i,
    .remote_ack_i, .i2c_forward_o, .i2c_ack_o, .bc_byte_valid_i,
    .bc_parity_ok_i, .bc_parity_check_on_o, .bc_parity_err_o,
    .cs_byte_valid_i, .cs_byte_idx_i, .cs_crc_slot_o, .cs_seq_len_o,
    .fwd_gpio_num_o, .fwd_gpio_en_o);
  slcr_imager_model far (.core_clk_i, .send_i(send), .vc_i(vc),
    .inter_i(inter), .pkt_o(pkt));
  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic hdr(input logic [1:0] v, input logic il);
    @(posedge core_clk_i);
    send <= 1'b1;
    vc <= v;
    inter <= il;
    @(posedge core_clk_i);
    send <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk_i);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    while (lp_ctrl_ignore_o === 1'b1 && n < 30000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(32'(n > 24996 && n < 25003), 32'h1);
    foreach (ra[k]) rd(ra[k], re[k]);
    wr(8'h27, 8'hFF);
    rd(8'h27, 8'h07);
    for (int c = 0; c < 4; c++) begin
      wr(8'h33, 8'(c));
      chk(fwd_gpio_num_o, c == 3 ? 4 : c);
      chk(fwd_gpio_en_o, c == 3 ? 4'hF : c == 2 ? 4'h3 : c);
      chk(cs_seq_len_o, 4'h8);
    end
    wr(8'h33, 8'h04);
    cs_byte_valid_i <= 1'b1;
    cs_byte_idx_i <= 4'h8;
    #1 chk({cs_seq_len_o, 3'h0, cs_crc_slot_o}, 8'h91);
    cs_byte_idx_i <= 4'h7;
    #1 chk(cs_crc_slot_o, 1'b0);
    cs_byte_valid_i <= 1'b0;
    // auto-ack and write qualifier sit on separate bits so every pair occurs
    for (int i = 0; i < 64; i++) begin
      wr(8'h32, {i[0], i[1], i[5], 5'h08});
      {remote_ack_i, i2c_is_write_i, i2c_addr_match_i} <= 3'(i >> 2);
      i2c_txn_i <= 1'b1;
      #1 chk(i2c_forward_o, i[0] | i[1] & i[2]);
      chk(i2c_ack_o, i[5] & i[3] | i[4]);
    end
    i2c_txn_i <= 1'b0;
    #1 chk({i2c_forward_o, i2c_ack_o}, 2'h0);
    for (int p = 0; p < 3; p++) begin
      wr(8'h32, p == 2 ? 8'h00 : 8'h08);
      bc_byte_valid_i <= 1'b1;
      bc_parity_ok_i <= p == 1;
      @(posedge core_clk_i);
      bc_byte_valid_i <= 1'b0;
      #1 chk({bc_parity_check_on_o, bc_parity_err_o},
             {p != 2, p == 0});
    end
    rd(8'h3F, 8'h02);
    wr(8'h31, 8'h20);
    hdr(2'h1, 1'b0);
    chk(pkt_hdr_view_o, 32'hC0DE0001);
    wr(8'h31, 8'h00);
    chk(pkt_hdr_view_o, 32'h5A5A0001);
    wr(8'h31, 8'h30);
    for (int v = 0; v < 4; v++) hdr(2'(v), 1'b1);
    for (int v = 3; v >= 0; v--) begin
      wr(8'h31, {2'(v), 6'h30});
      chk(pkt_hdr_view_o, {28'hC0DE000, 2'h0, 2'(v)});
    end
    hdr(2'h2, 1'b0);
    chk(pkt_hdr_view_o, 32'hC0DE0002);
    wr(8'h31, 8'hE0);
    chk(pkt_hdr_view_o, 32'hC0DE0002);
    // second reset mid-run, then a two-step start-up interval
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    wr(8'h31, 8'h21);
    chk(pkt_hdr_view_o, 32'h0);
    rd(8'h3F, 8'h01);
    n = 0;
    while (lp_ctrl_ignore_o === 1'b1 && n < 60000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(32'(n > 49990 && n < 50003), 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
